// >>> alarm_flag_mask_soft_reset.sv
// Sticky alarm flags, interrupt masks and self-clearing soft resets.
// Assumes live alarms synchronous to clk_sys and an AXI4-Lite master.
//
// How it works
// - Four sticky signal-missing flags, bits 3:0, set by live alarm, cleared by writing zero.
// - Sticky out-of-range flags in bits 7:4, cleared only by writing zero.
// - Inputs 0-2 use bits 0-2 and 4-6; reference has only bit 3.
// - Sticky unlock flag per loop in bits 3:0, cleared by writing zero.
// - Sticky holdover flag per loop in bits 7:4, cleared by writing zero.
// - Loops A-D use bits 0/4 to 3/7; loop D only in standard input mode.
// - Sticky calibration-busy flag per loop in bits 7:4, loop A at 4.
// - Per-loop enable makes holdover entry also raise unlock.
// - Fault masks: bit 0 calibration, 1 crystal, 5 bus timeout, 7:6 CMOS inputs.
// - Fault mask register resets to its documented default.
// - Input masks: signal-missing in 3:0, out-of-range in 7:4, same mapping.
// - Loop masks: unlock in 3:0, holdover in 7:4, per loop.
// - Calibration masks in bits 7:4, one per loop.
// - Whole-device reset bit 0 re-initializes, calibrates, reloads bandwidth, aligns outputs.
// - Per-loop reset bits 1-4 initialize and calibrate one loop each, except loop B bit 2, which resets all four loops.
// - All soft reset bits clear themselves after acting.
// - Loop B reset affects all loops.
// - Live signal-missing status follows the condition and never latches.
// - Internal fault flags latch on live condition, cleared by writing zero.
`default_nettype none

module alarm_flag_mask_soft_reset (
	input  wire logic                       clk_sys,
	input  wire logic                       nrst,
	input  wire alarm_flag_pkg::live_alarm_t live_alarms,
	input  wire logic                       std_input_mode,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [7:0]                 s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [7:0]                 s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            interrupt_out,
	output logic                            device_reset_pulse,
	output logic                            output_align_pulse,
	output logic                            bandwidth_reload_pulse,
	output logic [3:0]                      loop_reset_pulse
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [7:0]  fault_flags_q;
	logic [7:0]  input_flags_q;
	logic [7:0]  loop_flags_q;
	logic [3:0]  cal_flags_q;
	logic [3:0]  unlock_on_holdover_enable_q;
	logic [7:0]  fault_masks_q;
	logic [7:0]  input_alarm_masks_q;
	logic [7:0]  loop_lock_holdover_masks_q;
	logic [3:0]  loop_calibration_masks_q;
	logic [4:0]  soft_reset_q;

	logic        aw_got_q;
	logic        w_got_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        interrupt_q;
	logic        device_reset_q;
	logic        output_align_q;
	logic        bandwidth_reload_q;
	logic [3:0]  loop_reset_q;

	// ------------------------------------------------------------------
	// Write channel handshake
	// ------------------------------------------------------------------
	logic        aw_fire;
	logic        w_fire;
	logic        aw_have;
	logic        w_have;
	logic        do_write;
	logic        aw_got_d;
	logic        w_got_d;
	logic        bvalid_d;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [5:0]  wr_idx;
	logic        wr_byte0;

	assign aw_fire  = s_axi_awvalid & awready_q;
	assign w_fire   = s_axi_wvalid & wready_q;
	assign aw_have  = aw_got_q | aw_fire;
	assign w_have   = w_got_q | w_fire;
	assign do_write = aw_have & w_have & ~bvalid_q;
	assign aw_got_d = aw_have & ~do_write;
	assign w_got_d  = w_have & ~do_write;
	assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready);
	assign wr_addr  = aw_fire ? s_axi_awaddr : awaddr_q;
	assign wr_data  = w_fire ? s_axi_wdata : wdata_q;
	assign wr_strb  = w_fire ? s_axi_wstrb : wstrb_q;
	assign wr_idx   = wr_addr[7:2];
	// All registers are one byte wide, so only lane 0 can change them.
	assign wr_byte0 = do_write & wr_strb[0];

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			aw_got_q  <= aw_got_d;
			w_got_q   <= w_got_d;
			awready_q <= ~aw_got_d & ~bvalid_d;
			wready_q  <= ~w_got_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (aw_fire) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_fire) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end

	// ------------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------------
	logic        wr_mapped;
	logic        we_fault;
	logic        we_input;
	logic        we_loop;
	logic        we_cal;
	logic        we_enable;
	logic        we_fmask;
	logic        we_imask;
	logic        we_lmask;
	logic        we_cmask;
	logic        we_srst;

	always_comb begin
		wr_mapped = 1'b1;
		we_fault  = 1'b0;
		we_input  = 1'b0;
		we_loop   = 1'b0;
		we_cal    = 1'b0;
		we_enable = 1'b0;
		we_fmask  = 1'b0;
		we_imask  = 1'b0;
		we_lmask  = 1'b0;
		we_cmask  = 1'b0;
		we_srst   = 1'b0;
		if (wr_idx == alarm_flag_pkg::IDX_FAULT_FLAGS) begin
			we_fault = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_INPUT_FLAGS) begin
			we_input = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_LOOP_FLAGS) begin
			we_loop = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_CAL_FLAGS) begin
			we_cal = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_UNLOCK_HOLD) begin
			we_enable = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_FAULT_MASKS) begin
			we_fmask = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_INPUT_MASKS) begin
			we_imask = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_LOOP_MASKS) begin
			we_lmask = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_CAL_MASKS) begin
			we_cmask = wr_byte0;
		end else if (wr_idx == alarm_flag_pkg::IDX_SOFT_RESET) begin
			we_srst = wr_byte0;
		end else if (wr_idx != alarm_flag_pkg::IDX_LIVE_INPUT) begin
			wr_mapped = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bresp_q <= alarm_flag_pkg::RESP_OKAY;
		end else if (do_write) begin
			bresp_q <= wr_mapped ? alarm_flag_pkg::RESP_OKAY : alarm_flag_pkg::RESP_SLVERR;
		end
	end

	// ------------------------------------------------------------------
	// Live conditions
	// ------------------------------------------------------------------
	logic [7:0] live_input;
	logic [7:0] live_fault;
	logic [3:0] loop_in_use;
	logic [3:0] unlock_set;
	logic [3:0] holdover_set;

	// The reference input has no out-of-range detector, so bit 7 stays zero.
	assign live_input = {1'b0, live_alarms.freq_range_alarm,
		live_alarms.signal_missing_alarm};
	assign live_fault = {live_alarms.cmos_input_alarm, live_alarms.bus_timeout, 1'b0,
		live_alarms.crystal_lock_error, 1'b0, live_alarms.crystal_signal_missing,
		live_alarms.system_calibrating};
	assign loop_in_use = {std_input_mode, 3'h7};
	assign holdover_set = live_alarms.holdover_alarm & loop_in_use;
	assign unlock_set = (live_alarms.lock_lost_alarm
		| (live_alarms.holdover_alarm & unlock_on_holdover_enable_q)) & loop_in_use;

	// ------------------------------------------------------------------
	// Sticky flags: a set arriving with a clearing write wins
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			input_flags_q <= alarm_flag_pkg::FLAG_RESET;
		end else begin
			input_flags_q <= (input_flags_q & ~({8{we_input}} & ~wr_data[7:0]))
				| live_input;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loop_flags_q <= alarm_flag_pkg::FLAG_RESET;
		end else begin
			loop_flags_q <= (loop_flags_q & ~({8{we_loop}} & ~wr_data[7:0]))
				| {holdover_set, unlock_set};
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cal_flags_q <= 4'h0;
		end else begin
			cal_flags_q <= (cal_flags_q & ~({4{we_cal}} & ~wr_data[7:4]))
				| live_alarms.calibration_busy;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fault_flags_q <= alarm_flag_pkg::FLAG_RESET;
		end else begin
			fault_flags_q <= ((fault_flags_q & ~({8{we_fault}} & ~wr_data[7:0]))
				| live_fault) & alarm_flag_pkg::FAULT_IMPL_BITS;
		end
	end

	// ------------------------------------------------------------------
	// Masks and options
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			fault_masks_q <= alarm_flag_pkg::FAULT_MASK_RESET;
		end else if (we_fmask) begin
			fault_masks_q <= wr_data[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			input_alarm_masks_q <= alarm_flag_pkg::MASK_RESET;
		end else if (we_imask) begin
			input_alarm_masks_q <= wr_data[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loop_lock_holdover_masks_q <= alarm_flag_pkg::MASK_RESET;
		end else if (we_lmask) begin
			loop_lock_holdover_masks_q <= wr_data[7:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loop_calibration_masks_q <= 4'h0;
		end else if (we_cmask) begin
			loop_calibration_masks_q <= wr_data[7:4];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			unlock_on_holdover_enable_q <= alarm_flag_pkg::ENABLE_RESET;
		end else if (we_enable) begin
			unlock_on_holdover_enable_q <= wr_data[3:0];
		end
	end

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			interrupt_q <= 1'b0;
		end else begin
			interrupt_q <= |(input_flags_q & ~input_alarm_masks_q)
				| |(loop_flags_q & ~loop_lock_holdover_masks_q)
				| |(cal_flags_q & ~loop_calibration_masks_q)
				| |(fault_flags_q & ~fault_masks_q);
		end
	end

	// ------------------------------------------------------------------
	// Soft resets
	// ------------------------------------------------------------------
	// A written one lives for one cycle only, so a read never sees it set.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			soft_reset_q <= 5'h00;
		end else begin
			soft_reset_q <= we_srst ? wr_data[4:0] : 5'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			device_reset_q     <= 1'b0;
			output_align_q     <= 1'b0;
			bandwidth_reload_q <= 1'b0;
		end else begin
			device_reset_q     <= soft_reset_q[alarm_flag_pkg::SRST_ALL_BIT];
			output_align_q     <= soft_reset_q[alarm_flag_pkg::SRST_ALL_BIT];
			// Per-loop resets leave bandwidth alone; only the full reset reloads it.
			bandwidth_reload_q <= soft_reset_q[alarm_flag_pkg::SRST_ALL_BIT];
		end
	end

	generate
		for (genvar i = 0; i < alarm_flag_pkg::NUM_LOOPS; i++) begin : g_loop_reset
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					loop_reset_q[i] <= 1'b0;
				end else begin
					loop_reset_q[i] <= soft_reset_q[alarm_flag_pkg::SRST_ALL_BIT]
						| soft_reset_q[alarm_flag_pkg::SRST_LOOP_LSB + alarm_flag_pkg::LOOP_B]
						| soft_reset_q[alarm_flag_pkg::SRST_LOOP_LSB + i];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------
	logic [5:0] rd_idx;
	logic [7:0] rd_byte;
	logic       rd_mapped;
	logic       ar_fire;
	logic       rvalid_d;

	assign rd_idx   = s_axi_araddr[7:2];
	assign ar_fire  = s_axi_arvalid & arready_q;
	assign rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);

	always_comb begin
		rd_byte   = 8'h00;
		rd_mapped = 1'b1;
		if (rd_idx == alarm_flag_pkg::IDX_LIVE_INPUT) begin
			rd_byte = live_input;
		end else if (rd_idx == alarm_flag_pkg::IDX_FAULT_FLAGS) begin
			rd_byte = fault_flags_q;
		end else if (rd_idx == alarm_flag_pkg::IDX_INPUT_FLAGS) begin
			rd_byte = input_flags_q;
		end else if (rd_idx == alarm_flag_pkg::IDX_LOOP_FLAGS) begin
			rd_byte = loop_flags_q;
		end else if (rd_idx == alarm_flag_pkg::IDX_CAL_FLAGS) begin
			rd_byte = {cal_flags_q, 4'h0};
		end else if (rd_idx == alarm_flag_pkg::IDX_UNLOCK_HOLD) begin
			rd_byte = {4'h0, unlock_on_holdover_enable_q};
		end else if (rd_idx == alarm_flag_pkg::IDX_FAULT_MASKS) begin
			rd_byte = fault_masks_q;
		end else if (rd_idx == alarm_flag_pkg::IDX_INPUT_MASKS) begin
			rd_byte = input_alarm_masks_q;
		end else if (rd_idx == alarm_flag_pkg::IDX_LOOP_MASKS) begin
			rd_byte = loop_lock_holdover_masks_q;
		end else if (rd_idx == alarm_flag_pkg::IDX_CAL_MASKS) begin
			rd_byte = {loop_calibration_masks_q, 4'h0};
		end else if (rd_idx == alarm_flag_pkg::IDX_SOFT_RESET) begin
			rd_byte = 8'h00;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= alarm_flag_pkg::RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_fire) begin
				rdata_q <= {24'h00_0000, rd_byte};
				rresp_q <= rd_mapped ? alarm_flag_pkg::RESP_OKAY : alarm_flag_pkg::RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign s_axi_awready          = awready_q;
	assign s_axi_wready           = wready_q;
	assign s_axi_bvalid           = bvalid_q;
	assign s_axi_bresp            = bresp_q;
	assign s_axi_arready          = arready_q;
	assign s_axi_rvalid           = rvalid_q;
	assign s_axi_rdata            = rdata_q;
	assign s_axi_rresp            = rresp_q;
	assign interrupt_out          = interrupt_q;
	assign device_reset_pulse     = device_reset_q;
	assign output_align_pulse     = output_align_q;
	assign bandwidth_reload_pulse = bandwidth_reload_q;
	assign loop_reset_pulse       = loop_reset_q;

endmodule

`default_nettype wire

// >>> alarm_flag_pkg.sv
// Constants and types shared by the alarm flag, mask and soft reset block.
// Assumes a single 25 MHz system clock and an AXI4-Lite register master.
`default_nettype none

package alarm_flag_pkg;

	// ------------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------------
	localparam logic [5:0] IDX_LIVE_INPUT   = 6'h0D;
	localparam logic [5:0] IDX_FAULT_FLAGS  = 6'h11;
	localparam logic [5:0] IDX_INPUT_FLAGS  = 6'h12;
	localparam logic [5:0] IDX_LOOP_FLAGS   = 6'h13;
	localparam logic [5:0] IDX_CAL_FLAGS    = 6'h14;
	localparam logic [5:0] IDX_UNLOCK_HOLD  = 6'h16;
	localparam logic [5:0] IDX_FAULT_MASKS  = 6'h17;
	localparam logic [5:0] IDX_INPUT_MASKS  = 6'h18;
	localparam logic [5:0] IDX_LOOP_MASKS   = 6'h19;
	localparam logic [5:0] IDX_CAL_MASKS    = 6'h1A;
	localparam logic [5:0] IDX_SOFT_RESET   = 6'h1C;

	// ------------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------------
	localparam int NUM_LOOPS        = 4;
	localparam int LOOP_B           = 1;
	localparam int LOOP_D           = 3;
	localparam int SRST_ALL_BIT     = 0;
	localparam int SRST_LOOP_LSB    = 1;
	localparam int SRST_WIDTH       = 5;
	localparam int CAL_FIELD_LSB    = 4;

	// Bits of the fault flag register that exist; 2 and 4 read as zero.
	localparam logic [7:0] FAULT_IMPL_BITS  = 8'hEB;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] FAULT_MASK_RESET = 8'h35;
	localparam logic [7:0] MASK_RESET       = 8'h00;
	localparam logic [7:0] FLAG_RESET       = 8'h00;
	localparam logic [3:0] ENABLE_RESET     = 4'h0;

	// ------------------------------------------------------------------
	// AXI4-Lite response codes
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Live conditions from the detectors and loops
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] signal_missing_alarm;
		logic [2:0] freq_range_alarm;
		logic [3:0] lock_lost_alarm;
		logic [3:0] holdover_alarm;
		logic [3:0] calibration_busy;
		logic       system_calibrating;
		logic       crystal_signal_missing;
		logic       crystal_lock_error;
		logic       bus_timeout;
		logic [1:0] cmos_input_alarm;
	} live_alarm_t;

endpackage

`default_nettype wire

// >>> alarm_flag_checker_assertions.sv
// Checker for the register bus answers and soft reset pulses of the alarm block.
// Assumes it is bound into alarm_flag_mask_soft_reset and sees only its ports.
`default_nettype none

module alarm_flag_checker (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        interrupt_out,
	input wire logic        device_reset_pulse,
	input wire logic        output_align_pulse,
	input wire logic        bandwidth_reload_pulse,
	input wire logic [3:0]  loop_reset_pulse
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_write_resp_hold:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_data_hold:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_read_upper_zero:
		assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_reset_all_outputs:
		assert property (device_reset_pulse |-> output_align_pulse && bandwidth_reload_pulse
			&& loop_reset_pulse == 4'hF)
		else $error("device reset pulse incomplete");
	a_reset_write_pulse:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == 8'h70 && s_axi_wstrb[0] && s_axi_wdata[0]
			|-> ##[1:3] device_reset_pulse)
		else $error("device reset write gave no pulse");
	a_reload_only_all:
		assert property (bandwidth_reload_pulse |-> device_reset_pulse)
		else $error("bandwidth reload without device reset");
	a_device_pulse_once:
		assert property (device_reset_pulse |=> !device_reset_pulse)
		else $error("device reset pulse too long");
	a_loop_pulse_once:
		assert property (loop_reset_pulse != 4'h0 |=> loop_reset_pulse == 4'h0)
		else $error("loop reset pulse too long");
	a_loop_b_wide:
		assert property (loop_reset_pulse[1] |-> loop_reset_pulse == 4'hF)
		else $error("loop B reset not applied to all loops");

	cover property (device_reset_pulse);
	cover property (loop_reset_pulse == 4'h1);
	cover property ($rose(interrupt_out));
endmodule

bind alarm_flag_mask_soft_reset alarm_flag_checker alarm_flag_checker_inst (
	.clk_sys, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
	.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .interrupt_out, .device_reset_pulse,
	.output_align_pulse, .bandwidth_reload_pulse, .loop_reset_pulse
);

`default_nettype wire

// >>> alarm_flag_mask_soft_reset_bench.sv
// Self-checking bench for the alarm flag, mask and soft reset block.
// Assumes the package and the bound checker are compiled before it.
`default_nettype none

module alarm_flag_mask_soft_reset_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------------
	// Signals and design
	// ------------------------------------------------------------------
	logic        clk_sys = 1'h0;
	logic        nrst = 1'h0;
	logic [24:0] live = 25'h0;
	logic        std_mode = 1'h0;
	logic        awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
	logic        awr, wr, bv, arr, rv, irq, dev_p, aln_p, bw_p;
	logic [7:0]  awa = 8'h00, ara = 8'h00, v;
	logic [31:0] wd = 32'h0, rd;
	logic [3:0]  lrp;
	logic [1:0]  bresp, rresp, resp;
	int          fails = 0, total_checks = 0;
	int          cnt [6] = '{default: 0};

	initial forever #20 clk_sys = ~clk_sys;

	alarm_flag_mask_soft_reset alarm_flag_mask_soft_reset_inst (
		.clk_sys(clk_sys), .nrst(nrst), .live_alarms(live), .std_input_mode(std_mode),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
		.interrupt_out(irq), .device_reset_pulse(dev_p), .output_align_pulse(aln_p),
		.bandwidth_reload_pulse(bw_p), .loop_reset_pulse(lrp)
	);

	// Pulses are counted rather than sampled, so their exact cycle does not matter.
	always @(posedge clk_sys) begin
		for (int i = 0; i < 4; i++)
			cnt[i] <= cnt[i] + lrp[i];
		cnt[4] <= cnt[4] + (dev_p & aln_p);
		cnt[5] <= cnt[5] + bw_p;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s seen %0h wanted %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		logic aw_done, w_done;
		aw_done = 1'h0;
		w_done = 1'h0;
		@(posedge clk_sys);
		awv <= 1'h1;
		awa <= a;
		wv <= 1'h1;
		wd <= {24'h0, d};
		br <= 1'h1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			if (!aw_done && awr === 1'h1) begin
				awv <= 1'h0;
				aw_done = 1'h1;
			end
			if (!w_done && wr === 1'h1) begin
				wv <= 1'h0;
				w_done = 1'h1;
			end
		end
		do @(posedge clk_sys); while (bv !== 1'h1);
		resp = bresp;
		br <= 1'h0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		arv <= 1'h1;
		ara <= a;
		rr <= 1'h1;
		do @(posedge clk_sys); while (arr !== 1'h1);
		arv <= 1'h0;
		do @(posedge clk_sys); while (rv !== 1'h1);
		d = rd[7:0];
		resp = rresp;
		rr <= 1'h0;
	endtask

	task automatic pulse(input logic [24:0] l);
		@(posedge clk_sys);
		live <= l;
		@(posedge clk_sys);
		live <= 25'h0;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic read_is(input logic [7:0] a, exp, input string msg);
		rd_reg(a, v);
		check(v, exp, msg);
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_values();
		read_is(8'h5C, 8'h35, "fault mask reset");
		read_is(8'h48, 8'h00, "input flags reset");
		read_is(8'h7C, 8'h00, "unmapped read");
		check(resp, alarm_flag_pkg::RESP_SLVERR, "unmapped resp");
		wr_reg(8'h7C, 8'hFF);
		check(resp, alarm_flag_pkg::RESP_SLVERR, "unmapped write");
		read_is(8'h70, 8'h00, "soft reset reads zero");
		check(irq, 1'h0, "no interrupt after reset");
		$display("done reset values");
	endtask

	task automatic t_input_flags();
		// Bit vectors follow the package's live alarm field order, MSB first.
		@(posedge clk_sys);
		live <= 25'hA80000;
		read_is(8'h34, 8'h25, "live status follows");
		live <= 25'h0;
		read_is(8'h34, 8'h00, "live status released");
		read_is(8'h48, 8'h25, "flags stick");
		pulse(25'h1FC0000);
		read_is(8'h48, 8'h7F, "input flag map");
		wr_reg(8'h48, 8'hF0);
		read_is(8'h48, 8'h70, "missing flags cleared");
		wr_reg(8'h48, 8'h00);
		read_is(8'h48, 8'h00, "range flags cleared");
		$display("done input flags");
	endtask

	task automatic t_loop_flags();
		pulse(25'h3FC00);
		read_is(8'h4C, 8'h77, "loop D gated off");
		wr_reg(8'h4C, 8'h00);
		std_mode <= 1'h1;
		wr_reg(8'h58, 8'h04);
		read_is(8'h58, 8'h04, "enable readback");
		pulse(25'h3000);
		read_is(8'h4C, 8'hC4, "holdover raises unlock");
		wr_reg(8'h4C, 8'h00);
		read_is(8'h4C, 8'h00, "loop flags cleared");
		pulse(25'h240);
		read_is(8'h50, 8'h90, "calibration flags");
		wr_reg(8'h50, 8'h00);
		read_is(8'h50, 8'h00, "calibration cleared");
		$display("done loop flags");
	endtask

	task automatic irq_case(input logic [7:0] ma, mv, fa, input logic [24:0] l,
		input logic ex);
		wr_reg(ma, mv);
		pulse(l);
		check(irq, ex, "interrupt level");
		wr_reg(fa, 8'h00);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'h0, "interrupt cleared");
	endtask

	task automatic t_interrupts();
		irq_case(8'h5C, 8'h35, 8'h44, 25'h20, 1'h0);
		irq_case(8'h5C, 8'h35, 8'h44, 25'h4, 1'h0);
		irq_case(8'h5C, 8'h35, 8'h44, 25'h10, 1'h1);
		irq_case(8'h5C, 8'h02, 8'h44, 25'h10, 1'h0);
		irq_case(8'h5C, 8'h3F, 8'h44, 25'h3, 1'h1);
		irq_case(8'h5C, 8'hC0, 8'h44, 25'h3, 1'h0);
		irq_case(8'h60, 8'h01, 8'h48, 25'h200000, 1'h0);
		irq_case(8'h60, 8'hFE, 8'h48, 25'h200000, 1'h1);
		irq_case(8'h60, 8'h10, 8'h48, 25'h40000, 1'h0);
		irq_case(8'h64, 8'h10, 8'h4C, 25'h400, 1'h0);
		irq_case(8'h64, 8'hEF, 8'h4C, 25'h400, 1'h1);
		irq_case(8'h64, 8'h01, 8'h4C, 25'h4000, 1'h0);
		irq_case(8'h68, 8'h10, 8'h50, 25'h40, 1'h0);
		irq_case(8'h68, 8'hE0, 8'h50, 25'h40, 1'h1);
		$display("done interrupts");
	endtask

	task automatic t_soft_reset(input logic [7:0] d, input logic [5:0] e);
		int s [6];
		s = cnt;
		wr_reg(8'h70, d);
		repeat (6) @(posedge clk_sys);
		for (int i = 0; i < 6; i++)
			check(cnt[i] - s[i], {31'h0, e[i]}, "soft reset pulses");
		read_is(8'h70, 8'h00, "soft reset self clears");
		$display("done soft reset %0h", d);
	endtask

	// ------------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#400000;
		fails++;
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		nrst <= 1'h1;
		t_reset_values();
		t_input_flags();
		t_loop_flags();
		t_interrupts();
		t_soft_reset(8'h00, 6'h00);
		t_soft_reset(8'h01, 6'h3F);
		t_soft_reset(8'h02, 6'h01);
		t_soft_reset(8'h04, 6'h0F);
		t_soft_reset(8'h08, 6'h04);
		t_soft_reset(8'h10, 6'h08);
		wrap_up();
	end
endmodule

`default_nettype wire
